/* dac_mode_control_registers.sv */
// mode control register bank with attenuator ramps
`timescale 1ns/1ps
module dac_mode_control_registers
    import dac_mode_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_word_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic [7:0] left_applied_atten_o,
    output logic [7:0] right_applied_atten_o,
    output logic left_muted_o,
    output logic right_muted_o,
    output logic [2:0] audio_format_select_o,
    output logic format_reserved_o,
    output logic format_is_extfilt_o,
    output logic [1:0] deemph_rate_select_o,
    output logic deemph_enable_o,
    output logic [1:0] onebit_filter_perf_o,
    output logic [7:0] output_options_o,
    output logic onebit_mode_o,
    output logic external_filter_mode_o,
    output logic step_tick_o
);
    // -----------------------------------------------------------------
    // command decode
    // -----------------------------------------------------------------
    logic [6:0] cmd_idx;
    logic [7:0] cmd_data;
    logic wr_en;
    logic rd_en;
    logic [7:0] left_atten_code_q;
    logic [7:0] right_atten_code_q;
    logic [7:0] fmt_ctrl_q;
    logic [7:0] out_opts_q;
    logic [7:0] mode_cfg_q;
    logic [7:0] left_target_q;
    logic [7:0] right_target_q;
    logic [7:0] left_applied_q;
    logic [7:0] right_applied_q;
    logic [FRAME_CNT_W-1:0] frame_cnt_q;
    logic frame_tick;
    logic [2:0] div_cnt_q;
    logic [2:0] div_mask;
    logic step_tick;
    logic atten_load_gate;
    logic soft_mute;

    assign cmd_idx = cmd_word_i[CW_IDX_MSB:CW_IDX_LSB];
    assign cmd_data = cmd_word_i[7:0];
    assign wr_en = cmd_valid_i && (cmd_word_i[CW_RW_BIT] == CW_WRITE);
    assign rd_en = cmd_valid_i && (cmd_word_i[CW_RW_BIT] == CW_READ);
    assign atten_load_gate = fmt_ctrl_q[F_LOAD_GATE];
    assign soft_mute = fmt_ctrl_q[F_MUTE];

    // a code at or below the mute ceiling silences the channel
    function automatic logic is_mute_code(input logic [7:0] code);
        is_mute_code = (code <= ATTEN_MUTE_MAX);
    endfunction : is_mute_code

    // one half-dB step toward the target; codes under 15 collapse to zero
    function automatic logic [7:0] step_toward(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur == tgt)
            step_toward = cur;
        else if (is_mute_code(tgt) && cur <= (ATTEN_MUTE_MAX + 8'h01))
            step_toward = ATTEN_ZERO;
        else if (cur < tgt)
            step_toward = is_mute_code(cur) ? ATTEN_MUTE_MAX + 8'h01 : cur + 8'h01;
        else
            step_toward = cur - 8'h01;
    endfunction : step_toward

    // -----------------------------------------------------------------
    // register writes
    // -----------------------------------------------------------------
    // one process per register keeps each write path easy to follow
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            left_atten_code_q <= ATTEN_RST;
        else if (wr_en && (cmd_idx == IDX_LEFT_ATTEN))
            left_atten_code_q <= cmd_data;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            right_atten_code_q <= ATTEN_RST;
        else if (wr_en && (cmd_idx == IDX_RIGHT_ATTEN))
            right_atten_code_q <= cmd_data;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            fmt_ctrl_q <= FMT_CTRL_RST;
        else if (wr_en && (cmd_idx == IDX_FMT_CTRL))
            fmt_ctrl_q <= cmd_data;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            out_opts_q <= OUT_OPTS_RST;
        else if (wr_en && (cmd_idx == IDX_OUT_OPTS))
            out_opts_q <= cmd_data;
    end

    // unmapped indices fall through every process and are dropped silently
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            mode_cfg_q <= MODE_CFG_RST;
        else if (wr_en && (cmd_idx == IDX_MODE_CFG))
            mode_cfg_q <= cmd_data;
    end

    // -----------------------------------------------------------------
    // read-back
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            rd_valid_o <= 1'b0;
        else
            rd_valid_o <= rd_en;
    end

    // data holds between reads so a slow host may sample it late
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            rd_data_o <= 8'h00;
        else
        begin
            if (rd_en)
            begin
                if (cmd_idx == IDX_LEFT_ATTEN)
                    rd_data_o <= left_atten_code_q;
                else if (cmd_idx == IDX_RIGHT_ATTEN)
                    rd_data_o <= right_atten_code_q;
                else if (cmd_idx == IDX_FMT_CTRL)
                    rd_data_o <= fmt_ctrl_q;
                else if (cmd_idx == IDX_OUT_OPTS)
                    rd_data_o <= out_opts_q;
                else if (cmd_idx == IDX_MODE_CFG)
                    rd_data_o <= mode_cfg_q;
                else
                    rd_data_o <= 8'h00;
            end
        end
    end

    // -----------------------------------------------------------------
    // frame rate and step divider
    // -----------------------------------------------------------------
    assign frame_tick = (frame_cnt_q == FRAME_CNT_W'(FRAME_CYCLES - 1));

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            frame_cnt_q <= '0;
        else if (frame_tick)
            frame_cnt_q <= '0;
        else
            frame_cnt_q <= frame_cnt_q + FRAME_CNT_W'(1);
    end

    always_comb
    begin
        case (out_opts_q[F_ATS_MSB:F_ATS_LSB])
            2'b00: div_mask = 3'h0;
            2'b01: div_mask = 3'h1;
            2'b10: div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    end

    // every frame counts, every 1, 2, 4 or 8 frames makes a step
    assign step_tick = frame_tick && ((div_cnt_q & div_mask) == 3'h0);

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            div_cnt_q <= 3'h0;
        else if (frame_tick)
            div_cnt_q <= div_cnt_q + 3'h1;
    end

    // -----------------------------------------------------------------
    // load gate: targets only follow the codes while the gate is open
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            left_target_q <= ATTEN_RST;
        else if (atten_load_gate)
            left_target_q <= left_atten_code_q;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            right_target_q <= ATTEN_RST;
        else if (atten_load_gate)
            right_target_q <= right_atten_code_q;
    end

    // -----------------------------------------------------------------
    // applied level ramp; soft mute walks all the way down to zero
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            left_applied_q <= ATTEN_RST;
        else if (step_tick)
            // soft mute target zero keeps the step count within 256
            left_applied_q <= step_toward(left_applied_q,
                soft_mute ? ATTEN_ZERO : left_target_q);
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            right_applied_q <= ATTEN_RST;
        else if (step_tick)
            right_applied_q <= step_toward(right_applied_q,
                soft_mute ? ATTEN_ZERO : right_target_q);
    end

    // -----------------------------------------------------------------
    // registered outputs
    // -----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            left_applied_atten_o <= ATTEN_RST;
            left_muted_o <= 1'b0;
        end
        else
        begin
            left_applied_atten_o <= left_applied_q;
            left_muted_o <= is_mute_code(left_applied_q);
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            right_applied_atten_o <= ATTEN_RST;
            right_muted_o <= 1'b0;
        end
        else
        begin
            right_applied_atten_o <= right_applied_q;
            right_muted_o <= is_mute_code(right_applied_q);
        end
    end

    // the tick copy lags one cycle; the applied level outputs change one cycle after it
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
            step_tick_o <= 1'b0;
        else
            step_tick_o <= step_tick;
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            audio_format_select_o <= FMT_CTRL_RST[F_FMT_MSB:F_FMT_LSB];
            format_reserved_o <= 1'b0;
            format_is_extfilt_o <= 1'b0;
            external_filter_mode_o <= 1'b0;
        end
        else
        begin
            audio_format_select_o <= fmt_ctrl_q[F_FMT_MSB:F_FMT_LSB];
            // reserved codes are flagged only in normal format mode
            format_reserved_o <= !mode_cfg_q[F_EXTFILT]
                && (fmt_ctrl_q[F_FMT_MSB:F_FMT_LSB] >= FMT_RSV_LO);
            format_is_extfilt_o <= mode_cfg_q[F_EXTFILT];
            external_filter_mode_o <= mode_cfg_q[F_EXTFILT];
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            deemph_rate_select_o <= 2'b00;
            deemph_enable_o <= 1'b0;
            onebit_filter_perf_o <= 2'b00;
        end
        else
        begin
            // in one-bit mode the rate field steers the fir instead
            deemph_rate_select_o <= mode_cfg_q[F_ONEBIT] ? 2'b00
                : fmt_ctrl_q[F_DMF_MSB:F_DMF_LSB];
            onebit_filter_perf_o <= mode_cfg_q[F_ONEBIT]
                ? fmt_ctrl_q[F_DMF_MSB:F_DMF_LSB] : 2'b00;
            deemph_enable_o <= fmt_ctrl_q[F_DME];
        end
    end

    // option bits are passed on; apart from the ramp rate field that sets the step divider, their effects live outside this bank
    always_ff @(posedge ref_clk_i)
    begin
        if (!resetn_i)
        begin
            output_options_o <= OUT_OPTS_RST;
            onebit_mode_o <= 1'b0;
        end
        else
        begin
            output_options_o <= out_opts_q;
            onebit_mode_o <= mode_cfg_q[F_ONEBIT];
        end
    end
endmodule : dac_mode_control_registers

/* dac_mode_pkg.sv */
// constants for the dac mode control register bank
package dac_mode_pkg;
    // -----------------------------------------------------------------
    // control word layout
    // -----------------------------------------------------------------
    localparam int CW_RW_BIT = 15;
    localparam int CW_IDX_MSB = 14;
    localparam int CW_IDX_LSB = 8;
    localparam logic CW_WRITE = 1'b0;
    localparam logic CW_READ = 1'b1;
    // -----------------------------------------------------------------
    // register indices
    // -----------------------------------------------------------------
    localparam logic [6:0] IDX_LEFT_ATTEN = 7'h10;
    localparam logic [6:0] IDX_RIGHT_ATTEN = 7'h11;
    localparam logic [6:0] IDX_FMT_CTRL = 7'h12;
    localparam logic [6:0] IDX_OUT_OPTS = 7'h13;
    localparam logic [6:0] IDX_MODE_CFG = 7'h14;
    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int F_LOAD_GATE = 7;
    localparam int F_FMT_MSB = 6;
    localparam int F_FMT_LSB = 4;
    localparam int F_DMF_MSB = 3;
    localparam int F_DMF_LSB = 2;
    localparam int F_DME = 1;
    localparam int F_MUTE = 0;
    localparam int F_ATS_MSB = 6;
    localparam int F_ATS_LSB = 5;
    localparam int F_ONEBIT = 5;
    localparam int F_EXTFILT = 4;
    // -----------------------------------------------------------------
    // reset values and codes
    // -----------------------------------------------------------------
    localparam logic [7:0] ATTEN_RST = 8'hff;
    localparam logic [7:0] FMT_CTRL_RST = 8'h50;
    localparam logic [7:0] OUT_OPTS_RST = 8'h00;
    localparam logic [7:0] MODE_CFG_RST = 8'h00;
    localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0e;
    localparam logic [7:0] ATTEN_ZERO = 8'h00;
    localparam logic [2:0] FMT_RSV_LO = 3'h6;
    localparam logic [6:0] MUTE_RAMP_STEPS = 7'h7f;
    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int FRAME_RATE_HZ = 48000;
    localparam int CLK_HZ = 200000000;
    localparam int FRAME_CYCLES = CLK_HZ / FRAME_RATE_HZ;
    localparam int FRAME_CNT_W = 13;
endpackage : dac_mode_pkg

/* dac_mode_properties.sv */
// assertions on the ports of the mode control register bank
`timescale 1ns/1ps
module dac_mode_properties
    import dac_mode_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic rd_valid_o,
    input wire logic [7:0] rd_data_o,
    input wire logic [7:0] left_applied_atten_o,
    input wire logic left_muted_o,
    input wire logic [2:0] audio_format_select_o,
    input wire logic format_reserved_o,
    input wire logic format_is_extfilt_o,
    input wire logic [1:0] deemph_rate_select_o,
    input wire logic onebit_mode_o,
    input wire logic step_tick_o
);
    // ------
    // checks
    // ------
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence rd_req;
        cmd_valid_i && cmd_word_i[CW_RW_BIT];
    endsequence
    sequence wr_req;
        cmd_valid_i && !cmd_word_i[CW_RW_BIT];
    endsequence
    a_read_answer: assert property (rd_req |=> rd_valid_o) else $error("no answer");
    a_write_silent: assert property (wr_req |=> !rd_valid_o) else $error("write answered");
    a_answer_cause: assert property (rd_valid_o |-> $past(cmd_valid_i && cmd_word_i[15]))
        else $error("stray answer");
    a_data_hold: assert property (!rd_valid_o |-> $stable(rd_data_o)) else $error("data moved");
    a_tick_pulse: assert property (step_tick_o |=> !step_tick_o) else $error("long tick");
    a_mute_flag: assert property (left_muted_o == (left_applied_atten_o <= ATTEN_MUTE_MAX))
        else $error("mute flag");
    a_fmt_reserved: assert property (format_reserved_o
        == (audio_format_select_o >= FMT_RSV_LO && !format_is_extfilt_o)) else $error("rsv");
    a_onebit_rate: assert property (onebit_mode_o |-> deemph_rate_select_o == 2'h0)
        else $error("rate in one-bit mode");
    // one code per step, except the jumps across the mute region
    a_atten_step: assert property ($changed(left_applied_atten_o) |->
        (left_applied_atten_o == $past(left_applied_atten_o) + 8'h01 ||
        left_applied_atten_o == $past(left_applied_atten_o) - 8'h01 ||
        left_applied_atten_o == 8'h00 || $past(left_applied_atten_o) == 8'h00))
        else $error("jump");
endmodule : dac_mode_properties

bind dac_mode_control_registers dac_mode_properties u_props
(
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
    .left_applied_atten_o(left_applied_atten_o), .left_muted_o(left_muted_o),
    .audio_format_select_o(audio_format_select_o), .format_reserved_o(format_reserved_o),
    .format_is_extfilt_o(format_is_extfilt_o), .deemph_rate_select_o(deemph_rate_select_o),
    .onebit_mode_o(onebit_mode_o), .step_tick_o(step_tick_o)
);

/* host_ctrl_model.sv */
// host controller model that issues control words
`timescale 1ns/1ps
module host_ctrl_model
(
    input wire logic ref_clk_i,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i,
    output logic cmd_valid_o,
    output logic [15:0] cmd_word_o
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_word_o = 16'h0000;
    end
    // idle word is inverted so stale data never looks like a command
    task automatic xfer(input logic rw, input logic [6:0] idx, input logic [7:0] dat,
        output logic ok, output logic [7:0] rd);
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b1;
        cmd_word_o = {rw, idx, dat};
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        cmd_word_o = ~cmd_word_o;
        ok = rd_valid_i;
        rd = rd_data_i;
    endtask : xfer
endmodule : host_ctrl_model

/* testbench.sv */
// self-checking bench for the mode control register bank
`timescale 1ns/1ps
module testbench;
    import dac_mode_pkg::*;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cmd_valid_i, rd_valid_o, left_muted_o, right_muted_o, format_reserved_o, ok;
    logic format_is_extfilt_o, deemph_enable_o, onebit_mode_o, external_filter_mode_o;
    logic step_tick_o;
    logic [15:0] cmd_word_i;
    logic [7:0] rd_data_o, left_applied_atten_o, right_applied_atten_o, output_options_o, rd;
    logic [2:0] audio_format_select_o;
    logic [1:0] deemph_rate_select_o, onebit_filter_perf_o;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int n;
    dac_mode_control_registers dut
    (
        .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
        .cmd_word_i(cmd_word_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .left_applied_atten_o(left_applied_atten_o), .left_muted_o(left_muted_o),
        .right_applied_atten_o(right_applied_atten_o), .right_muted_o(right_muted_o),
        .audio_format_select_o(audio_format_select_o), .format_reserved_o(format_reserved_o),
        .format_is_extfilt_o(format_is_extfilt_o), .deemph_rate_select_o(deemph_rate_select_o),
        .deemph_enable_o(deemph_enable_o), .onebit_filter_perf_o(onebit_filter_perf_o),
        .output_options_o(output_options_o), .onebit_mode_o(onebit_mode_o),
        .external_filter_mode_o(external_filter_mode_o), .step_tick_o(step_tick_o)
    );
    host_ctrl_model host
    (
        .ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o),
        .cmd_valid_o(cmd_valid_i), .cmd_word_o(cmd_word_i)
    );
    always #2.5 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [6:0] idx, input logic [7:0] dat);
        host.xfer(CW_WRITE, idx, dat, ok, rd);
        check(16'(ok), 16'h0000);
    endtask : wr
    task automatic rd_chk(input logic [6:0] idx, input logic [7:0] exp);
        host.xfer(CW_READ, idx, 8'h00, ok, rd);
        check({7'h00, ok, rd}, {8'h01, exp});
    endtask : rd_chk
    task automatic settle;
        repeat (3) @(posedge ref_clk_i);
        #1;
    endtask : settle
    // bounded wait; the global cycle ceiling also catches a missing tick
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge ref_clk_i);
            #1;
            cnt++;
        end
        while (step_tick_o !== 1'b1 && cnt < 40000);
    endtask : wait_tick
    task automatic tick_chk(input logic [15:0] exp);
        wait_tick(n);
        settle();
        check({left_applied_atten_o, right_applied_atten_o}, exp);
        check({left_muted_o, right_muted_o}, 16'h0000);
    endtask : tick_chk
    task automatic test_regs;
        rd_chk(IDX_LEFT_ATTEN, ATTEN_RST);
        rd_chk(IDX_FMT_CTRL, FMT_CTRL_RST);
        rd_chk(IDX_OUT_OPTS, OUT_OPTS_RST);
        for (int i = 16; i < 21; i++)
            wr(7'(i), 8'ha5 ^ 8'(i));
        wr(7'h20, 8'h3c);
        for (int i = 16; i < 21; i++)
            rd_chk(7'(i), 8'ha5 ^ 8'(i));
        rd_chk(7'h20, 8'h00);
        for (int i = 16; i < 21; i++)
            wr(7'(i), (i < 18) ? ATTEN_RST : ((i == 18) ? FMT_CTRL_RST : 8'h00));
        $display("test_regs done");
    endtask : test_regs
    task automatic test_fields;
        for (int i = 0; i < 8; i++)
        begin
            wr(IDX_FMT_CTRL, {1'b0, 3'(i), 2'(i), 1'(i), 1'b0});
            settle();
            check(16'(audio_format_select_o), 16'(i));
            check(16'(format_reserved_o), 16'(i >= 6));
            check({deemph_rate_select_o, deemph_enable_o}, {2'(i), 1'(i)});
        end
        wr(IDX_OUT_OPTS, 8'h9f);
        wr(IDX_MODE_CFG, 8'h10);
        settle();
        check(16'(output_options_o), 16'h009f);
        check({format_reserved_o, format_is_extfilt_o, external_filter_mode_o}, 3'h3);
        wr(IDX_MODE_CFG, 8'h20);
        wr(IDX_FMT_CTRL, 8'h5c);
        settle();
        check({onebit_mode_o, onebit_filter_perf_o, deemph_rate_select_o}, 5'h1c);
        wr(IDX_MODE_CFG, 8'h00);
        wr(IDX_OUT_OPTS, 8'h00);
        wr(IDX_FMT_CTRL, FMT_CTRL_RST);
        $display("test_fields done");
    endtask : test_fields
    task automatic test_ramp;
        wr(IDX_LEFT_ATTEN, 8'hfd);
        wr(IDX_RIGHT_ATTEN, 8'hfe);
        tick_chk(16'hffff);
        wr(IDX_FMT_CTRL, 8'hd0);
        tick_chk(16'hfefe);
        tick_chk(16'hfdfe);
        wr(IDX_FMT_CTRL, 8'hd1);
        tick_chk(16'hfcfd);
        wr(IDX_FMT_CTRL, 8'hd0);
        tick_chk(16'hfdfe);
        wr(IDX_FMT_CTRL, FMT_CTRL_RST);
        wr(IDX_LEFT_ATTEN, 8'hff);
        tick_chk(16'hfdfe);
        $display("test_ramp done");
    endtask : test_ramp
    task automatic test_rate;
        int g;
        for (int a = 0; a < 2; a++)
        begin
            g = (a + 1) * FRAME_CYCLES;
            wr(IDX_OUT_OPTS, {1'b0, 2'(a), 5'h00});
            wait_tick(n);
            wait_tick(n);
            check(16'(n > g - 2 && n < g + 2), 16'h0001);
        end
        wr(IDX_OUT_OPTS, OUT_OPTS_RST);
        $display("test_rate done");
    endtask : test_rate
    task automatic test_done;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    always @(posedge ref_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 80000)
        begin
            num_errors++;
            test_done();
        end
    end
    initial
    begin
        repeat (10) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        test_regs();
        test_fields();
        test_ramp();
        test_rate();
        test_done();
    end
endmodule : testbench
